// ### src/chf_cfg.svh
// Purpose: shared constants for the coprocessor handshake link
// Assumes: 32-bit instruction words, two-bit handshake buses
// Notes:   definitions only
`ifndef CHF_CFG_SVH
`define CHF_CFG_SVH
`define CHF_HS_ABSENT   2'h2
`define CHF_HS_WAIT     2'h0
`define CHF_HS_GO       2'h1
`define CHF_HS_LAST     2'h3
`define CHF_CLS_MSB     27
`define CHF_CLS_LSB     26
`define CHF_CLS_CP      2'h3
`define CHF_LDST_BIT    25
`define CHF_LOAD_BIT    20
`define CHF_CPN_MSB     11
`define CHF_CPN_LSB     8
`define CHF_CPN_DEBUG   4'he
`define CHF_CPN_OWN     4'h5
`define CHF_ADDR_STEP   32'h0000_0004
`define CHF_FIFO_DEPTH  16
`define CHF_WORD_W      32
`define CHF_CNT_W       5
`endif

// ### src/chf_cop_end.sv
// Purpose: coprocessor side: pipeline follower, handshake replies, load buffer
// Assumes: one coprocessor number answers; loads arrive on the user port
// Notes:   load words queue in a FIFO; a full FIFO turns decode and waiting-state replies to wait
// Notes on behaviour
// RULE_01 - every fetched word enters both pipelines
// RULE_02 - qualifier and advance high request fetch
// RULE_03 - advance samples, moves fetch to decode, decode on
// RULE_04 - follower holds when no advance occurs
// RULE_05 - execute stage runs on the ungated clock
// RULE_06 - go flag marks passed coprocessor instruction
// RULE_07 - go flag held while busy; low abandons
// RULE_08 - cancel may come with nothing executing
// RULE_09 - cancel sampled edge after first execute
// RULE_10 - core reads decode then execute handshake
// RULE_11 - absent reply makes the core trap
// RULE_12 - wait reply stalls core in busy loop
// RULE_13 - busy loop ends on absent, go, last
// RULE_14 - no state change before go flag and go/last
// RULE_15 - go means execute now, another cycle follows
// RULE_16 - go while two or more words remain
// RULE_17 - core drives address and data request low
// RULE_18 - waits, run of go, then last
// RULE_19 - decode reply ready by end of decode
// RULE_20 - wait allowed for internal debug coprocessor
// RULE_21 - absent 10, wait 00, go 01, last 11
// RULE_22 - sample go flag every busy cycle
// RULE_23 - reset empties follower stages
`include "chf_cfg.svh"
module chf_fifo
#(
   parameter int W = `CHF_WORD_W,
   parameter int D = `CHF_FIFO_DEPTH
)
(
   // clock and reset
   input  wire logic         i_mclk,
   input  wire logic         i_reset_n,
   // fill side
   input  wire logic [W-1:0] i_wdata,
   input  wire logic         i_wvalid,
   output logic              o_wready,
   // drain side
   output logic [W-1:0]      o_rdata,
   output logic              o_rvalid,
   input  wire logic         i_rready
);
   localparam int AW = $clog2(D);
   logic [W-1:0] mem [D];
   logic [AW:0]  wp_r, rp_r;
   logic         full_r, empty_r, push, pop;
   logic [AW:0]  wp_n, rp_n;

   assign push = i_wvalid & ~full_r;
   assign pop  = i_rready & ~empty_r;
   assign wp_n = push ? wp_r + 1'b1 : wp_r;
   assign rp_n = pop ? rp_r + 1'b1 : rp_r;

   always_ff @(posedge i_mclk)
   begin
      if (push)
         mem[wp_r[AW-1:0]] <= i_wdata;
   end

   always_ff @(posedge i_mclk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         wp_r    <= '0;
         rp_r    <= '0;
         full_r  <= 1'b0;
         empty_r <= 1'b1;
      end
      else
      begin
         wp_r    <= wp_n;
         rp_r    <= rp_n;
         full_r  <= (wp_n[AW] != rp_n[AW]) && (wp_n[AW-1:0] == rp_n[AW-1:0]);
         empty_r <= (wp_n == rp_n);
      end
   end

   assign o_wready = ~full_r;
   assign o_rvalid = ~empty_r;
   assign o_rdata  = mem[rp_r[AW-1:0]];
endmodule // chf_fifo

module chf_cop_end
(
   // clock and reset
   input  wire logic        i_mclk,
   input  wire logic        i_reset_n,
   // coprocessor status
   input  wire logic        i_busy,
   input  wire logic [4:0]  i_word_count,
   // load data from memory
   input  wire logic [31:0] i_load_data,
   input  wire logic        i_load_valid,
   // buffered load words to the coprocessor datapath
   output logic [31:0]      o_word,
   output logic             o_word_valid,
   input  wire logic        i_word_ready,
   // results
   output logic             o_commit,
   output logic             o_abandon,
   output logic             o_cancelled,
   // link
   chf_if.cop               lnk
);
   logic        adv, pend_r;
   logic [31:0] fet_r;
   logic        fet_v_r;
   chf_pkg::chf_hs_type dhs_r, ehs_r;
   chf_pkg::chf_cop_st_type st_r;
   logic [4:0]  left_r;
   logic        first_r, commit_r, aband_r, canc_r, fifo_wready, take_word;
   logic        start;

   function automatic chf_pkg::chf_hs_type reply(input logic [31:0] w, input logic stall,
                                                 input logic [4:0] words);
      if (w[`CHF_CLS_MSB:`CHF_CLS_LSB] != `CHF_CLS_CP)
         reply = `CHF_HS_ABSENT;
      else if (w[`CHF_CPN_MSB:`CHF_CPN_LSB] == `CHF_CPN_DEBUG)
         reply = `CHF_HS_WAIT;                                           // RULE_20
      else if (w[`CHF_CPN_MSB:`CHF_CPN_LSB] != `CHF_CPN_OWN)
         reply = `CHF_HS_ABSENT;                                         // RULE_11
      else if (stall)
         reply = `CHF_HS_WAIT;                                           // RULE_12
      else if (!w[`CHF_LDST_BIT] && words > 5'h01)
         reply = `CHF_HS_GO;                                             // RULE_16
      else
         reply = `CHF_HS_LAST;                                           // RULE_21
   endfunction

   assign adv   = lnk.clock_qualifier & lnk.pipeline_advance;            // RULE_02
   assign start = adv & lnk.clock_qualifier & fet_v_r;

   // follower moves only on qualified advance edges
   always_ff @(posedge i_mclk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         pend_r  <= 1'b0;                                                // RULE_23
         fet_v_r <= 1'b0;
         fet_r   <= 32'h0000_0000;
      end
      else if (adv)                                                      // RULE_03 RULE_04
      begin
         pend_r  <= 1'b1;
         fet_r   <= lnk.instruction_bus;                                 // RULE_01
         fet_v_r <= pend_r;
      end
   end

   // decode reply tracks the word that sits in decode, held ready ahead of the edge
   always_ff @(posedge i_mclk or negedge i_reset_n)
   begin
      if (!i_reset_n)
         dhs_r <= `CHF_HS_WAIT;
      else
         dhs_r <= reply(adv ? lnk.instruction_bus : fet_r, i_busy | ~fifo_wready,
                        i_word_count);                                   // RULE_19
   end

   // execute stage: ungated clock so it keeps running while the core stalls
   always_ff @(posedge i_mclk or negedge i_reset_n)                      // RULE_05
   begin
      if (!i_reset_n)
      begin
         st_r     <= chf_pkg::COP_IDLE;
         ehs_r    <= `CHF_HS_WAIT;
         left_r   <= 5'h00;
         first_r  <= 1'b0;
         commit_r <= 1'b0;
         aband_r  <= 1'b0;
         canc_r   <= 1'b0;
      end
      else
      begin
         commit_r <= 1'b0;
         aband_r  <= 1'b0;
         canc_r   <= 1'b0;
         first_r  <= 1'b0;
         case (st_r)
            chf_pkg::COP_IDLE:
            begin
               if (start && reply(fet_r, 1'b0, i_word_count) != `CHF_HS_ABSENT
                   && fet_r[`CHF_CPN_MSB:`CHF_CPN_LSB] == `CHF_CPN_OWN)
               begin
                  first_r <= 1'b1;
                  left_r  <= fet_r[`CHF_LDST_BIT] ? 5'h01 : i_word_count;
                  st_r    <= (dhs_r == `CHF_HS_WAIT) ? chf_pkg::COP_WAITING
                                                     : chf_pkg::COP_RUN;
                  ehs_r   <= dhs_r;
               end
            end
            chf_pkg::COP_WAITING:
            begin
               if (!lnk.execute_go_flag || (first_r && lnk.late_abort_cancel))
               begin
                  st_r    <= chf_pkg::COP_IDLE;                          // RULE_22 RULE_07
                  aband_r <= 1'b1;
               end
               else if (!i_busy && fifo_wready)
               begin
                  st_r  <= chf_pkg::COP_RUN;                             // RULE_18
                  ehs_r <= (left_r > 5'h01) ? `CHF_HS_GO : `CHF_HS_LAST;
               end
               else
                  ehs_r <= `CHF_HS_WAIT;
            end
            chf_pkg::COP_RUN:
            begin
               if (!lnk.execute_go_flag)
               begin
                  st_r    <= chf_pkg::COP_IDLE;                          // RULE_15
                  aband_r <= 1'b1;
               end
               else if (first_r && lnk.late_abort_cancel)
               begin
                  st_r   <= chf_pkg::COP_IDLE;                           // RULE_09 RULE_08
                  canc_r <= 1'b1;
               end
               else if (ehs_r == `CHF_HS_LAST)
               begin
                  st_r     <= chf_pkg::COP_IDLE;                         // RULE_14
                  commit_r <= 1'b1;
                  ehs_r    <= `CHF_HS_WAIT;
               end
               else if (lnk.clock_qualifier)
               begin
                  left_r <= left_r - 5'h01;                              // RULE_16
                  ehs_r  <= (left_r > 5'h02) ? `CHF_HS_GO : `CHF_HS_LAST;
               end
            end
            default: st_r <= chf_pkg::COP_IDLE;
         endcase
      end
   end

   // a load word is only kept while the instruction is live in run and no late cancel is pending
   assign take_word = i_load_valid & (st_r == chf_pkg::COP_RUN) & lnk.execute_go_flag
                      & ~(first_r & lnk.late_abort_cancel);

   chf_fifo #(.W(`CHF_WORD_W), .D(`CHF_FIFO_DEPTH)) u_load_fifo
   (
      .i_mclk    (i_mclk),
      .i_reset_n (i_reset_n),
      .i_wdata   (i_load_data),
      .i_wvalid  (take_word),
      .o_wready  (fifo_wready),
      .o_rdata   (o_word),
      .o_rvalid  (o_word_valid),
      .i_rready  (i_word_ready)
   );

   assign o_commit              = commit_r;
   assign o_abandon             = aband_r;
   assign o_cancelled           = canc_r;
   assign lnk.decode_handshake  = dhs_r;
   assign lnk.execute_handshake = ehs_r;
endmodule // chf_cop_end

// ### src/chf_core_end.sv
// Purpose: processor core side of the coprocessor handshake link
// Assumes: user supplies instruction words, condition result, interrupt
// Notes:   a word is taken at every edge where o_instruction_bus_ready is high
`include "chf_cfg.svh"
module chf_core_end
(
   // clock and reset
   input  wire logic        i_mclk,
   input  wire logic        i_reset_n,
   // instruction feed
   input  wire logic [31:0] i_instruction_bus,
   input  wire logic        i_instruction_bus_valid,
   output logic             o_instruction_bus_ready,
   // core status
   input  wire logic        i_hold,
   input  wire logic        i_cond_pass,
   input  wire logic        i_irq,
   input  wire logic        i_abort_prev,
   input  wire logic [31:0] i_xfer_addr,
   output logic             o_undef_trap,
   output logic             o_cp_done,
   // link
   chf_if.core              lnk
);
   logic        cq_r, pa_r, go_r, lc_r, dmr_n_r, trap_r, done_r;
   logic        fet_v_r, dec_v_r;
   logic [31:0] bus_r, dec_r, addr_r;
   logic        ldst_r;
   chf_pkg::chf_core_st_type st_r;
   logic        adv, enter_cp;
   chf_pkg::chf_hs_type hs;

   function automatic logic is_cp(input logic [31:0] w);
      // debug-unit words never wait on the external handshake
      is_cp = (w[`CHF_CLS_MSB:`CHF_CLS_LSB] == `CHF_CLS_CP)
              && (w[`CHF_CPN_MSB:`CHF_CPN_LSB] != `CHF_CPN_DEBUG);   // RULE_20
   endfunction

   assign adv      = cq_r & pa_r;                                        // RULE_02
   assign enter_cp = adv & dec_v_r & is_cp(dec_r) & i_cond_pass;
   assign hs       = (st_r == chf_pkg::CORE_IDLE) ? lnk.decode_handshake
                                                  : lnk.execute_handshake; // RULE_10

   // qualifier and fetch request; no fetch while an instruction holds execute
   always_ff @(posedge i_mclk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         cq_r <= 1'b0;
         pa_r <= 1'b0;
      end
      else
      begin
         cq_r <= ~i_hold;
         pa_r <= (st_r == chf_pkg::CORE_IDLE) & ~enter_cp;
      end
   end

   // pipeline mirrored by the follower across the link
   always_ff @(posedge i_mclk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         bus_r   <= 32'h0000_0000;
         fet_v_r <= 1'b0;
         dec_r   <= 32'h0000_0000;
         dec_v_r <= 1'b0;
      end
      else if (adv)                                                      // RULE_01
      begin
         bus_r   <= i_instruction_bus;
         fet_v_r <= i_instruction_bus_valid;
         dec_r   <= bus_r;
         dec_v_r <= fet_v_r;
      end
   end

   // execute stage handshake sequencer
   always_ff @(posedge i_mclk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         st_r    <= chf_pkg::CORE_IDLE;
         go_r    <= 1'b0;
         trap_r  <= 1'b0;
         done_r  <= 1'b0;
         ldst_r  <= 1'b0;
      end
      else
      begin
         trap_r  <= 1'b0;
         done_r  <= 1'b0;
         if (!cq_r)
         begin
            st_r <= st_r;
         end
         else if (st_r == chf_pkg::CORE_IDLE)
         begin
            go_r <= enter_cp;                                            // RULE_06
            if (enter_cp)
            begin
               ldst_r <= ~dec_r[`CHF_LDST_BIT];
               case (hs)
                  `CHF_HS_ABSENT:
                  begin
                     go_r   <= 1'b0;
                     trap_r <= 1'b1;                                     // RULE_11
                  end
                  `CHF_HS_WAIT: st_r <= chf_pkg::CORE_BUSY;              // RULE_12
                  `CHF_HS_GO:   st_r <= chf_pkg::CORE_MULTI;             // RULE_15
                  default:      st_r <= chf_pkg::CORE_FINAL;
               endcase
            end
         end
         else if (st_r == chf_pkg::CORE_FINAL)
         begin
            st_r   <= chf_pkg::CORE_IDLE;
            go_r   <= 1'b0;
            done_r <= 1'b1;
         end
         else if (st_r == chf_pkg::CORE_BUSY && i_irq)
         begin
            st_r <= chf_pkg::CORE_IDLE;                                  // RULE_07
            go_r <= 1'b0;
         end
         else
         begin
            case (hs)                                                    // RULE_13
               `CHF_HS_ABSENT:
               begin
                  st_r   <= chf_pkg::CORE_IDLE;
                  go_r   <= 1'b0;
                  trap_r <= 1'b1;
               end
               `CHF_HS_WAIT: st_r <= (st_r == chf_pkg::CORE_MULTI) ? chf_pkg::CORE_MULTI
                                                                   : chf_pkg::CORE_BUSY;
               `CHF_HS_GO:   st_r <= chf_pkg::CORE_MULTI;
               default:      st_r <= chf_pkg::CORE_FINAL;
            endcase
         end
      end
   end

   // data-side request and address for load and store transfers
   always_ff @(posedge i_mclk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         dmr_n_r <= 1'b1;
         addr_r  <= 32'h0000_0000;
      end
      else if (enter_cp && cq_r && st_r == chf_pkg::CORE_IDLE)
      begin
         dmr_n_r <= dec_r[`CHF_LDST_BIT] | (hs == `CHF_HS_ABSENT);      // RULE_17
         addr_r  <= i_xfer_addr;
      end
      else if (cq_r && ldst_r && (st_r == chf_pkg::CORE_MULTI || st_r == chf_pkg::CORE_FINAL))
      begin
         dmr_n_r <= (st_r == chf_pkg::CORE_FINAL);
         addr_r  <= addr_r + `CHF_ADDR_STEP;
      end
      else if (cq_r)
      begin
         dmr_n_r <= ~(ldst_r & st_r != chf_pkg::CORE_IDLE & st_r != chf_pkg::CORE_BUSY);
      end
   end

   // cancel stands through the first execute cycle, sampled at its closing edge
   always_ff @(posedge i_mclk or negedge i_reset_n)
   begin
      if (!i_reset_n)
         lc_r <= 1'b0;
      else
         lc_r <= enter_cp & i_abort_prev;                                // RULE_08 RULE_09
   end

   assign o_instruction_bus_ready          = adv;
   assign o_undef_trap           = trap_r;
   assign o_cp_done              = done_r;
   assign lnk.clock_qualifier    = cq_r;
   assign lnk.pipeline_advance   = pa_r;
   assign lnk.instruction_bus    = bus_r;
   assign lnk.execute_go_flag    = go_r;
   assign lnk.late_abort_cancel  = lc_r;
   assign lnk.data_mem_request_n = dmr_n_r;
   assign lnk.xfer_addr          = addr_r;
endmodule // chf_core_end

// ### src/chf_if.sv
// Purpose: signals between processor core and attached coprocessor
// Assumes: single clock shared by both ends
// Notes:   no clocking block; the bench joins the two ends here
interface chf_if;
   logic        clock_qualifier;
   logic        pipeline_advance;
   logic [31:0] instruction_bus;
   logic        execute_go_flag;
   logic        late_abort_cancel;
   logic        data_mem_request_n;
   logic [31:0] xfer_addr;
   logic [1:0]  decode_handshake;
   logic [1:0]  execute_handshake;
   modport core (output clock_qualifier, pipeline_advance, instruction_bus, execute_go_flag,
                 late_abort_cancel, data_mem_request_n, xfer_addr,
                 input decode_handshake, execute_handshake);
   modport cop  (input clock_qualifier, pipeline_advance, instruction_bus, execute_go_flag,
                 late_abort_cancel, data_mem_request_n, xfer_addr,
                 output decode_handshake, execute_handshake);
endinterface

// ### src/chf_pkg.sv
// Purpose: types shared by both ends of the coprocessor link
// Assumes: constants come from chf_cfg.svh
// Notes:   state enums carry no explicit codes
package chf_pkg;
   typedef logic [1:0] chf_hs_type;
   typedef enum logic [1:0] {CORE_IDLE, CORE_BUSY, CORE_MULTI, CORE_FINAL} chf_core_st_type;
   typedef enum logic [1:0] {COP_IDLE, COP_WAITING, COP_RUN} chf_cop_st_type;
endpackage

// ### verif/chf_link_properties.sv
// Purpose: concurrent checks on the link between core end and coprocessor end
// Assumes: one clock, asynchronous active-low reset
// Notes:   sees only the link signals; the bench instantiates it beside the link
`include "chf_cfg.svh"
module chf_link_properties
(
   // clock and reset
   input  wire logic        i_mclk,
   input  wire logic        i_reset_n,
   // link
   input  wire logic        clock_qualifier,
   input  wire logic        pipeline_advance,
   input  wire logic [31:0] instruction_bus,
   input  wire logic        execute_go_flag,
   input  wire logic        late_abort_cancel,
   input  wire logic        data_mem_request_n,
   input  wire logic [31:0] xfer_addr,
   input  wire logic [1:0]  decode_handshake,
   input  wire logic [1:0]  execute_handshake
);
   timeunit 1ns;
   timeprecision 1ns;

   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (!i_reset_n);

   sequence s_adv_absent;
      clock_qualifier && pipeline_advance && !execute_go_flag
         && decode_handshake == `CHF_HS_ABSENT;
   endsequence
   sequence s_xfer_run;
      !data_mem_request_n ##1 !data_mem_request_n;
   endsequence
   sequence s_last_seen;
      execute_go_flag && clock_qualifier && execute_handshake == `CHF_HS_LAST;
   endsequence

   property p_go_rise;
      $rose(execute_go_flag) |-> $past(clock_qualifier) && $past(pipeline_advance)
         && $past(decode_handshake) != `CHF_HS_ABSENT;
   endproperty
   property p_absent_no_go;
      s_adv_absent |=> !execute_go_flag;
   endproperty
   property p_addr_step;
      s_xfer_run |-> xfer_addr == $past(xfer_addr)
         || xfer_addr == $past(xfer_addr) + `CHF_ADDR_STEP;
   endproperty
   property p_last_ends;
      s_last_seen |-> ##[1:4] !execute_go_flag;
   endproperty
   property p_req_with_go;
      !data_mem_request_n |-> execute_go_flag;
   endproperty
   property p_cancel_slot;
      late_abort_cancel |-> execute_go_flag && !$past(execute_go_flag);
   endproperty
   property p_bus_held;
      !(clock_qualifier && pipeline_advance) |=> $stable(instruction_bus);
   endproperty
   property p_go_not_dropped;
      $fell(execute_go_flag) |-> $past(execute_handshake) != `CHF_HS_GO;
   endproperty

   a_go_rise: assert property (p_go_rise)
      else $error("go flag rose without a qualified decode reply");
   a_absent_no_go: assert property (p_absent_no_go)
      else $error("go flag raised after an absent reply");
   a_addr_step: assert property (p_addr_step)
      else $error("transfer address moved by other than one word");
   a_last_ends: assert property (p_last_ends)
      else $error("execution continued long after last");
   a_req_with_go: assert property (p_req_with_go)
      else $error("data request without go flag");
   a_cancel_slot: assert property (p_cancel_slot)
      else $error("late cancel outside the first execute cycle");
   a_bus_held: assert property (p_bus_held)
      else $error("instruction bus changed without an advance");
   a_go_not_dropped: assert property (p_go_not_dropped)
      else $error("go flag dropped while another cycle was requested");
endmodule // chf_link_properties

// ### verif/coprocessor_handshake_follower_test.sv
// Purpose: self-checking bench joining core end and coprocessor end
// Assumes: own coprocessor number answers, the debug number is skipped, others are absent
// Notes:   pulse outputs are counted by a monitor so tasks compare deltas
`include "chf_cfg.svh"
`define CHECK_EQ(got, exp) begin n_checks++; if ((got) !== (exp)) begin num_errors++; \
   $display("ERROR t=%0t mismatch got %0h exp %0h", $time, got, exp); end end
module coprocessor_handshake_follower_test;
   timeunit 1ns;
   timeprecision 1ns;

   logic        i_mclk, i_reset_n, i_instruction_bus_valid, o_instruction_bus_ready, i_hold, i_cond_pass;
   logic        i_irq, i_abort_prev, o_undef_trap, o_cp_done, i_busy, o_word_valid;
   logic        i_word_ready, o_commit, o_abandon, o_cancelled, req_q;
   logic [31:0] i_instruction_bus, i_xfer_addr, o_word, first_addr;
   logic [4:0]  i_word_count;
   int          num_errors, n_checks, c_commit, c_trap, c_aband, c_canc, c_done, c_pop;

   chf_if chf_if_inst ();

   chf_core_end chf_core_end_inst (
      .i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_instruction_bus(i_instruction_bus),
      .i_instruction_bus_valid(i_instruction_bus_valid), .o_instruction_bus_ready(o_instruction_bus_ready), .i_hold(i_hold),
      .i_cond_pass(i_cond_pass), .i_irq(i_irq), .i_abort_prev(i_abort_prev),
      .i_xfer_addr(i_xfer_addr), .o_undef_trap(o_undef_trap), .o_cp_done(o_cp_done),
      .lnk(chf_if_inst));

   chf_cop_end chf_cop_end_inst (
      .i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_busy(i_busy),
      .i_word_count(i_word_count), .i_load_data(32'h0000_5a5a), .i_load_valid(1'b1),
      .o_word(o_word), .o_word_valid(o_word_valid), .i_word_ready(i_word_ready),
      .o_commit(o_commit), .o_abandon(o_abandon), .o_cancelled(o_cancelled),
      .lnk(chf_if_inst));

   chf_link_properties chf_link_properties_inst (
      .i_mclk(i_mclk), .i_reset_n(i_reset_n),
      .clock_qualifier(chf_if_inst.clock_qualifier),
      .pipeline_advance(chf_if_inst.pipeline_advance),
      .instruction_bus(chf_if_inst.instruction_bus),
      .execute_go_flag(chf_if_inst.execute_go_flag),
      .late_abort_cancel(chf_if_inst.late_abort_cancel),
      .data_mem_request_n(chf_if_inst.data_mem_request_n),
      .xfer_addr(chf_if_inst.xfer_addr),
      .decode_handshake(chf_if_inst.decode_handshake),
      .execute_handshake(chf_if_inst.execute_handshake));

   initial
   begin
      i_mclk = 1'b0;
      forever #20 i_mclk = ~i_mclk;
   end

   always @(posedge i_mclk)
   begin
      if (o_commit === 1'b1) c_commit++;
      if (o_undef_trap === 1'b1) c_trap++;
      if (o_abandon === 1'b1) c_aband++;
      if (o_cancelled === 1'b1) c_canc++;
      if (o_cp_done === 1'b1) c_done++;
      if (o_word_valid === 1'b1 && i_word_ready === 1'b1) c_pop++;
      if (chf_if_inst.data_mem_request_n === 1'b0 && req_q === 1'b1)
         first_addr = chf_if_inst.xfer_addr;
      req_q = chf_if_inst.data_mem_request_n;
   end

   function automatic logic [31:0] cp_word(input logic [3:0] cpn);
      return {4'he, `CHF_CLS_CP, 1'b0, 13'h0000, cpn, 8'h00};
   endfunction

   task automatic end_sim;
      $display("checks=%0d errors=%0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic feed(input logic [31:0] w);
      int k;
      k = 0;
      @(posedge i_mclk);
      i_instruction_bus <= w;
      i_instruction_bus_valid <= 1'b1;
      do
      begin
         @(negedge i_mclk);
         k++;
      end
      while (o_instruction_bus_ready !== 1'b1 && k < 50);
      @(posedge i_mclk);
      i_instruction_bus_valid <= 1'b0;
      i_instruction_bus <= 32'h0000_0000;
   endtask

   task automatic wait_ev;
      int k, s;
      k = 0;
      s = c_done + c_trap + c_aband + c_canc;
      while (k < 200 && c_done + c_trap + c_aband + c_canc == s)
      begin
         @(posedge i_mclk);
         k++;
      end
      repeat (4) @(posedge i_mclk);
   endtask

   task automatic t_load(input logic [4:0] n, input int stall);
      int p, c, k;
      p = c_pop;
      c = c_commit;
      @(posedge i_mclk);
      i_word_count <= n;
      i_word_ready <= (stall == 0);
      feed(cp_word(`CHF_CPN_OWN));
      if (stall > 0)
      begin
         repeat (stall) @(negedge i_mclk);
         `CHECK_EQ(o_word_valid, 1'b1)
         `CHECK_EQ(c_commit, c)
         @(posedge i_mclk);
         i_word_ready <= 1'b1;
      end
      wait_ev;
      k = 0;
      while (o_word_valid === 1'b1 && k < 40)
      begin
         @(posedge i_mclk);
         k++;
      end
      `CHECK_EQ(c_commit - c, 1)
      `CHECK_EQ(c_pop - p, int'(n))
      `CHECK_EQ(first_addr, 32'h0000_1000)
      $display("load test done, words=%0d", n);
   endtask

   task automatic t_single(input logic [3:0] cpn, input logic pass, input int exp_trap);
      int t, c;
      t = c_trap;
      c = c_commit;
      @(posedge i_mclk);
      i_word_count <= 5'h01;
      i_cond_pass <= pass;
      feed(cp_word(cpn));
      wait_ev;
      i_cond_pass <= 1'b1;
      `CHECK_EQ(c_trap - t, exp_trap)
      `CHECK_EQ(c_commit - c, int'(pass && cpn == `CHF_CPN_OWN))
      $display("single test done, unit=%0d", cpn);
   endtask

   task automatic t_busy(input logic irq);
      int a, c;
      a = c_aband;
      c = c_commit;
      @(posedge i_mclk);
      i_busy <= 1'b1;
      feed(cp_word(`CHF_CPN_OWN));
      repeat (12) @(negedge i_mclk);
      `CHECK_EQ(chf_if_inst.execute_go_flag, 1'b1)
      `CHECK_EQ(chf_if_inst.execute_handshake, `CHF_HS_WAIT)
      @(posedge i_mclk);
      i_irq <= irq;
      i_busy <= irq;
      wait_ev;
      i_irq <= 1'b0;
      i_busy <= 1'b0;
      `CHECK_EQ(c_aband - a, int'(irq))
      `CHECK_EQ(c_commit - c, int'(!irq))
      $display("busy-wait test done, irq=%0d", irq);
   endtask

   task automatic t_cancel;
      int n;
      n = c_canc;
      @(posedge i_mclk);
      i_abort_prev <= 1'b1;
      repeat (10) @(posedge i_mclk);
      `CHECK_EQ(c_canc, n)
      feed(cp_word(`CHF_CPN_OWN));
      wait_ev;
      i_abort_prev <= 1'b0;
      `CHECK_EQ(c_canc - n, 1)
      $display("late cancel test done");
   endtask

   task automatic t_hold;
      @(posedge i_mclk);
      i_hold <= 1'b1;
      repeat (3) @(negedge i_mclk);
      `CHECK_EQ(chf_if_inst.clock_qualifier, 1'b0)
      `CHECK_EQ(o_instruction_bus_ready, 1'b0)
      @(posedge i_mclk);
      i_hold <= 1'b0;
      $display("hold test done");
   endtask

   initial
   begin
      i_reset_n = 1'b0;
      i_instruction_bus = 32'h0000_0000;
      i_instruction_bus_valid = 1'b0;
      i_hold = 1'b0;
      i_cond_pass = 1'b1;
      i_irq = 1'b0;
      i_abort_prev = 1'b0;
      i_xfer_addr = 32'h0000_1000;
      i_busy = 1'b0;
      i_word_count = 5'h01;
      i_word_ready = 1'b1;
      req_q = 1'b1;
      first_addr = 32'h0000_0000;
      repeat (3) @(negedge i_mclk);
      `CHECK_EQ(chf_if_inst.decode_handshake, `CHF_HS_WAIT)
      `CHECK_EQ(chf_if_inst.data_mem_request_n, 1'b1)
      `CHECK_EQ(o_word_valid, 1'b0)
      @(posedge i_mclk);
      i_reset_n <= 1'b1;
      t_load(5'h01, 0);
      t_load(5'h02, 0);
      t_load(5'h04, 0);
      t_load(5'h10, 4);
      t_single(4'h3, 1'b1, 1);
      t_single(`CHF_CPN_DEBUG, 1'b1, 0);
      t_single(`CHF_CPN_OWN, 1'b0, 0);
      t_busy(1'b1);
      t_busy(1'b0);
      t_cancel;
      t_hold;
      end_sim;
   end

   // whole run is well under a thousand cycles; this bound only cuts a hang
   initial
   begin
      repeat (20000) @(posedge i_mclk);
      num_errors++;
      $display("ERROR t=%0t watchdog expired", $time);
      end_sim;
   end
endmodule // coprocessor_handshake_follower_test
